// ### pkg/arm_pkg.sv
// Constants, register map and mode encodings for the alarm relay mode controller.
// Assumes a single 250 MHz clock and an AHB-Lite register bus with 32-bit data.
package arm_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ        = 250;
  localparam int TOGGLE_MS      = 1000;
  localparam int TOGGLE_CYC     = TOGGLE_MS * 1000 * CLK_MHZ;

  // ---------------------------------------------------------------
  // Alarm code vector layout: errors first, warnings after
  // ---------------------------------------------------------------
  localparam int N_ERR          = 96;
  localparam int N_WARN         = 64;
  localparam int N_CODE         = N_ERR + N_WARN;
  localparam int N_WORD         = N_CODE / 32;
  localparam int WARN_UV        = N_ERR + 2;
  localparam int WARN_GRID_LO   = N_ERR + 3;
  localparam int WARN_GRID_HI   = N_ERR + 7;

  // ---------------------------------------------------------------
  // Dusk/dawn hysteresis as a ratio: release below 7/10 of activation
  // ---------------------------------------------------------------
  localparam int VIN_W          = 16;
  localparam logic [3:0] HYST_NUM = 4'h7;
  localparam logic [3:0] HYST_DEN = 4'ha;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_VACT     = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h14;
  localparam logic [7:0] ADDR_SEL_BASE = 8'h20;
  localparam logic [7:0] ADDR_LAT_BASE = 8'h40;

  // Control field layout and reset values.
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_MODE_W    = 4;
  localparam logic [3:0]  MODE_RST  = 4'h0;
  localparam logic [15:0] VACT_RST  = 16'h0000;

  // Interrupt bits: relay switched, relay released, mode changed.
  localparam int N_IRQ          = 3;
  localparam int IRQ_ON         = 0;
  localparam int IRQ_OFF        = 1;
  localparam int IRQ_MODE       = 2;

  // ---------------------------------------------------------------
  // Mode field encodings and one-hot state of the active mode
  // ---------------------------------------------------------------
  localparam logic [3:0] MC_PRODUCTION  = 4'h0;
  localparam logic [3:0] MC_ALL_NOLATCH = 4'h1;
  localparam logic [3:0] MC_CONF_NOLAT  = 4'h2;
  localparam logic [3:0] MC_CONF_LATCH  = 4'h3;
  localparam logic [3:0] MC_EXT_MATRIX  = 4'h4;
  localparam logic [3:0] MC_CHAIN_AUTO  = 4'h5;
  localparam logic [3:0] MC_CHAIN_FOLL  = 4'h6;
  localparam logic [3:0] MC_DUSK_DAWN   = 4'h7;
  localparam logic [3:0] MC_ALL_LATCH   = 4'h8;

  typedef enum logic [8:0] {
    M_PRODUCTION   = 9'h001,
    M_ALL_NOLATCH  = 9'h002,
    M_CONF_NOLAT   = 9'h004,
    M_CONF_LATCH   = 9'h008,
    M_EXT_MATRIX   = 9'h010,
    M_CHAIN_AUTO   = 9'h020,
    M_CHAIN_FOLL   = 9'h040,
    M_DUSK_DAWN    = 9'h080,
    M_ALL_LATCH    = 9'h100
  } arm_mode_t;

endpackage : arm_pkg

// ### hw/arm_relay_ctrl.sv
// Alarm relay mode controller: one relay with normally-open and normally-closed
// contacts, driven by one of nine modes, configured over AHB-Lite.
// Assumes alarm codes, grid state and input voltage arrive synchronous to clk.
`timescale 1ns/10ps

module arm_relay_ctrl
  import arm_pkg::*;
#(
  parameter int TOGGLE_CYCLES = TOGGLE_CYC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [7:0]        haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // Inverter state
  input  wire logic              expansion_fitted,
  input  wire logic              grid_connected,
  input  wire logic              normal_operation,
  input  wire logic [N_CODE-1:0] code_active,
  input  wire logic [VIN_W-1:0]  input_voltage,
  input  wire logic              chain_in,
  // Relay contacts and interrupt
  output logic                   relay_no_closed,
  output logic                   relay_nc_closed,
  output logic                   irq
);

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  logic [CTRL_MODE_W-1:0] mode_field_q;
  logic [VIN_W-1:0]       vact_q;
  logic [N_IRQ-1:0]       irq_stat_q;
  logic [N_IRQ-1:0]       irq_en_q;
  logic [31:0]            sel_q [N_WORD];
  logic [31:0]            lat_q [N_WORD];
  logic                   wr_pend_q;
  logic [7:0]             wr_addr_q;
  logic                   relay_q;
  logic                   latch_q;
  logic                   dusk_q;
  logic                   toggle_q;
  arm_mode_t              mode_q;

  logic addr_phase;
  assign addr_phase = hsel & htrans[1] & hready;

  // Zero-wait slave: every access completes in its first data-phase cycle.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr_q <= haddr;
      end
    end
  end

  logic wr_ctrl;
  logic wr_vact;
  logic wr_irq_en;
  logic wr_irq_clr;
  assign wr_ctrl    = wr_pend_q && (wr_addr_q == ADDR_CTRL);
  assign wr_vact    = wr_pend_q && (wr_addr_q == ADDR_VACT);
  assign wr_irq_en  = wr_pend_q && (wr_addr_q == ADDR_IRQ_EN);
  assign wr_irq_clr = wr_pend_q && (wr_addr_q == ADDR_IRQ_CLR);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_field_q <= MODE_RST;
      vact_q       <= VACT_RST;
      irq_en_q     <= '0;
    end else begin
      if (wr_ctrl) begin
        mode_field_q <= hwdata[CTRL_MODE_LSB +: CTRL_MODE_W];
      end
      if (wr_vact) begin
        vact_q <= hwdata[VIN_W-1:0];
      end
      if (wr_irq_en) begin
        irq_en_q <= hwdata[N_IRQ-1:0];
      end
    end
  end

  // Code selection and per-code latch choice, one word per 32 codes.
  genvar gi;
  generate
    for (gi = 0; gi < N_WORD; gi++) begin : g_sel
      localparam logic [7:0] SEL_A = ADDR_SEL_BASE + 8'(gi * 4);
      localparam logic [7:0] LAT_A = ADDR_LAT_BASE + 8'(gi * 4);
      always_ff @(posedge clk) begin
        if (!rstn) begin
          sel_q[gi] <= 32'h0000_0000;
          lat_q[gi] <= 32'h0000_0000;
        end else begin
          if (wr_pend_q && (wr_addr_q == SEL_A)) begin
            sel_q[gi] <= hwdata;
          end
          if (wr_pend_q && (wr_addr_q == LAT_A)) begin
            lat_q[gi] <= hwdata;
          end
        end
      end
    end
  endgenerate

  // Read data is registered at the address phase; unmapped addresses read zero.
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h0000_0000;
    case (haddr)
      ADDR_CTRL:     rd_d[CTRL_MODE_LSB +: CTRL_MODE_W] = mode_field_q;
      ADDR_STATUS:   rd_d = {13'h0000, mode_q, 6'h00, latch_q, dusk_q, toggle_q, relay_q};
      ADDR_VACT:     rd_d[VIN_W-1:0] = vact_q;
      ADDR_IRQ_STAT: rd_d[N_IRQ-1:0] = irq_stat_q;
      ADDR_IRQ_EN:   rd_d[N_IRQ-1:0] = irq_en_q;
      default: begin
        for (int i = 0; i < N_WORD; i++) begin
          if (haddr == ADDR_SEL_BASE + 8'(i * 4)) begin
            rd_d = sel_q[i];
          end
          if (haddr == ADDR_LAT_BASE + 8'(i * 4)) begin
            rd_d = lat_q[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      hrdata <= rd_d;
    end
  end

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  // An unknown field value falls back to production, so exactly one mode is live.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_q <= M_PRODUCTION;
    end else begin
      case (mode_field_q)
        MC_ALL_NOLATCH: mode_q <= M_ALL_NOLATCH;
        MC_CONF_NOLAT:  mode_q <= M_CONF_NOLAT;
        MC_CONF_LATCH:  mode_q <= M_CONF_LATCH;
        MC_EXT_MATRIX:  mode_q <= M_EXT_MATRIX;
        MC_CHAIN_AUTO:  mode_q <= M_CHAIN_AUTO;
        MC_CHAIN_FOLL:  mode_q <= M_CHAIN_FOLL;
        MC_DUSK_DAWN:   mode_q <= M_DUSK_DAWN;
        MC_ALL_LATCH:   mode_q <= M_ALL_LATCH;
        default:        mode_q <= M_PRODUCTION;
      endcase
    end
  end

  logic      mode_chg;
  arm_mode_t mode_prev_q;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_prev_q <= M_PRODUCTION;
    end else begin
      mode_prev_q <= mode_q;
    end
  end
  assign mode_chg = (mode_q != mode_prev_q);

  // ---------------------------------------------------------------
  // Alarm terms
  // ---------------------------------------------------------------
  logic [N_CODE-1:0] sel_vec;
  logic [N_CODE-1:0] lat_vec;
  always_comb begin
    for (int i = 0; i < N_WORD; i++) begin
      sel_vec[i*32 +: 32] = sel_q[i];
      lat_vec[i*32 +: 32] = lat_q[i];
    end
  end

  logic any_err;
  logic any_code;
  logic grid_warn;
  logic sel_alarm;
  logic mtx_nolat;
  logic mtx_lat;
  assign any_err   = |code_active[N_ERR-1:0];
  assign any_code  = |code_active;
  assign grid_warn = |code_active[WARN_GRID_HI:WARN_GRID_LO];
  assign sel_alarm = |(code_active & sel_vec);
  assign mtx_nolat = |(code_active & sel_vec & ~lat_vec);
  assign mtx_lat   = |(code_active & sel_vec & lat_vec);

  // Latched alarms release once the inverter runs normally on the grid, or at once on a mode change.
  logic latch_set;
  logic latch_rel;
  always_comb begin
    case (mode_q)
      M_ALL_LATCH:  latch_set = any_code;
      M_CONF_LATCH: latch_set = sel_alarm;
      M_EXT_MATRIX: latch_set = mtx_lat;
      default:      latch_set = 1'b0;
    endcase
  end
  assign latch_rel = normal_operation & grid_connected & ~latch_set;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      latch_q <= 1'b0;
    end else if (mode_chg) begin
      latch_q <= 1'b0;
    end else if (latch_set) begin
      latch_q <= 1'b1;
    end else if (latch_rel) begin
      latch_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Dusk/dawn hysteresis
  // ---------------------------------------------------------------
  logic [VIN_W+3:0] vin_scaled;
  logic [VIN_W+3:0] vact_scaled;
  assign vin_scaled  = {4'h0, input_voltage} * {{VIN_W{1'b0}}, HYST_DEN};
  assign vact_scaled = {4'h0, vact_q} * {{VIN_W{1'b0}}, HYST_NUM};

  always_ff @(posedge clk) begin
    if (!rstn) begin
      dusk_q <= 1'b0;
    end else if (mode_chg) begin
      dusk_q <= 1'b0;
    end else if (input_voltage > vact_q) begin
      dusk_q <= 1'b1;
    end else if (vin_scaled < vact_scaled) begin
      dusk_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Cyclic toggling for a persistent selected alarm
  // ---------------------------------------------------------------
  // A full 32-bit counter keeps the default period of one second reachable.
  logic [31:0] tog_cnt_q;
  logic        tog_active;
  assign tog_active = sel_alarm & (mode_q == M_CONF_NOLAT);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tog_cnt_q <= 32'h0000_0000;
      toggle_q  <= 1'b0;
    end else if (!tog_active || mode_chg) begin
      tog_cnt_q <= 32'h0000_0000;
      toggle_q  <= 1'b0;
    end else if (tog_cnt_q == 32'(TOGGLE_CYCLES - 1)) begin
      tog_cnt_q <= 32'h0000_0000;
      toggle_q  <= ~toggle_q;
    end else begin
      tog_cnt_q <= tog_cnt_q + 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // Relay drive
  // ---------------------------------------------------------------
  logic relay_d;
  always_comb begin
    case (mode_q)
      M_PRODUCTION:  relay_d = grid_connected;
      M_ALL_NOLATCH: relay_d = any_err | grid_warn;
      M_CONF_NOLAT:  relay_d = sel_alarm & ~toggle_q;
      M_CONF_LATCH:  relay_d = sel_alarm | latch_q;
      M_EXT_MATRIX:  relay_d = mtx_nolat | mtx_lat | latch_q;
      M_CHAIN_AUTO:  relay_d = sel_alarm;
      M_CHAIN_FOLL:  relay_d = chain_in;
      M_DUSK_DAWN:   relay_d = dusk_q;
      M_ALL_LATCH:   relay_d = any_code | latch_q;
      default:       relay_d = 1'b0;
    endcase
    if (!expansion_fitted || mode_chg) begin
      relay_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      relay_q         <= 1'b0;
      relay_no_closed <= 1'b0;
      relay_nc_closed <= 1'b1;
    end else begin
      relay_q         <= relay_d;
      relay_no_closed <= relay_d;
      relay_nc_closed <= ~relay_d;
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  // Set wins over a clear written in the same cycle.
  logic [N_IRQ-1:0] irq_evt;
  logic [N_IRQ-1:0] irq_clr;
  assign irq_evt[IRQ_ON]   = relay_d & ~relay_q;
  assign irq_evt[IRQ_OFF]  = ~relay_d & relay_q;
  assign irq_evt[IRQ_MODE] = mode_chg;
  assign irq_clr = wr_irq_clr ? hwdata[N_IRQ-1:0] : '0;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_stat_q <= '0;
      irq        <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
      irq        <= |(((irq_stat_q & ~irq_clr) | irq_evt) & irq_en_q);
    end
  end

endmodule : arm_relay_ctrl

// ### bench/arm_relay_ctrl_asserts.sv
// Checker for the alarm relay controller, watching its top-level ports only.
// Assumes single AHB-Lite transfers and inputs that change just after a rising edge.
`timescale 1ns/10ps
module arm_relay_chk
  import arm_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              rstn,
  // Register bus
  input wire logic              hsel,
  input wire logic [7:0]        haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  // Inverter state and relay
  input wire logic              expansion_fitted,
  input wire logic              grid_connected,
  input wire logic              normal_operation,
  input wire logic [N_CODE-1:0] code_active,
  input wire logic [VIN_W-1:0]  input_voltage,
  input wire logic              relay_no_closed,
  input wire logic              relay_nc_closed
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic        wr_q;
  logic [7:0]  wa_q;
  logic [3:0]  mode_q;
  logic [15:0] vact_q;
  logic [2:0]  calm_q;
  logic        ok;
  logic        hit;
  logic [19:0] v10;
  logic [19:0] a7;
  assign ok  = (calm_q == 3'h7) && expansion_fitted;
  assign hit = |code_active[N_ERR-1:0] || |code_active[WARN_GRID_HI:WARN_GRID_LO];
  assign v10 = 20'(input_voltage) * 20'd10;
  assign a7  = 20'(vact_q) * 20'd7;

  // Shadow of the mode and activation voltage, so the mode rules can be judged.
  always_ff @(posedge clk) begin
    wr_q <= rstn && hsel && htrans[1] && hready && hwrite;
    wa_q <= haddr;
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_q <= MODE_RST;
    end else if (wr_q && wa_q == ADDR_CTRL) begin
      mode_q <= hwdata[3:0];
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      vact_q <= VACT_RST;
    end else if (wr_q && wa_q == ADDR_VACT) begin
      vact_q <= hwdata[15:0];
    end
  end
  // A mode write restarts the count; only settled modes are judged.
  always_ff @(posedge clk) begin
    if (!rstn || (wr_q && wa_q == ADDR_CTRL)) begin
      calm_q <= 3'h0;
    end else if (calm_q != 3'h7) begin
      calm_q <= calm_q + 3'h1;
    end
  end

  sequence s_mode_write;
    wr_q && wa_q == ADDR_CTRL && hwdata[3:0] != mode_q;
  endsequence
  sequence s_rest_soon;
    ##[1:4] !relay_no_closed;
  endsequence

  chk_contact_pair: assert property (relay_nc_closed == !relay_no_closed)
    else $error("contacts not complementary");
  chk_no_expansion: assert property (!expansion_fitted |=> !relay_no_closed)
    else $error("relay switched without expansion");
  chk_prod_follow: assert property (ok && mode_q == MC_PRODUCTION
    |=> relay_no_closed == $past(grid_connected)) else $error("production relay wrong");
  chk_nolatch_follow: assert property (ok && mode_q == MC_ALL_NOLATCH
    |=> relay_no_closed == $past(hit)) else $error("no-latch relay wrong");
  chk_latch_set: assert property (ok && mode_q == MC_ALL_LATCH && |code_active
    |=> relay_no_closed) else $error("latch mode missed a code");
  chk_latch_hold: assert property (ok && mode_q == MC_ALL_LATCH && relay_no_closed
    && !(normal_operation && grid_connected) |=> relay_no_closed) else $error("latch dropped");
  chk_dusk_on: assert property (ok && mode_q == MC_DUSK_DAWN && input_voltage > vact_q
    ##1 ok |=> relay_no_closed) else $error("dusk relay not switched");
  chk_dusk_off: assert property (ok && mode_q == MC_DUSK_DAWN && v10 < a7
    |=> ##1 !relay_no_closed) else $error("dusk relay not released");
  chk_dusk_hold: assert property (ok && mode_q == MC_DUSK_DAWN && v10 >= a7
    ##1 (ok && relay_no_closed) |=> relay_no_closed) else $error("dusk hysteresis lost");
  chk_mode_rest: assert property (s_mode_write |-> s_rest_soon)
    else $error("no rest cycle after mode change");
endmodule : arm_relay_chk

bind arm_relay_ctrl arm_relay_chk u_chk (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .expansion_fitted, .grid_connected, .normal_operation, .code_active,
  .input_voltage, .relay_no_closed, .relay_nc_closed);

// ### bench/arm_relay_lamp.sv
// Model of a lamp wired to the relay contacts; counts flashes and flags contact conflicts.
// Assumes the contacts are sampled on the controller clock and share its reset.
`timescale 1ns/10ps
module arm_relay_lamp (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rstn,
  // Contacts
  input  wire logic   relay_no_closed,
  input  wire logic   relay_nc_closed,
  // Load state
  output logic        lamp_on,
  output logic [15:0] flash_cnt,
  output logic        bad_q
);
  logic prev_q;
  assign lamp_on = relay_no_closed;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prev_q    <= 1'b0;
      flash_cnt <= 16'h0000;
    end else begin
      prev_q <= relay_no_closed;
      if (relay_no_closed && !prev_q) begin
        flash_cnt <= flash_cnt + 16'h0001;
      end
    end
  end
  // Both contacts closed or both open would short or drop the load.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      bad_q <= 1'b0;
    end else if (relay_no_closed === relay_nc_closed) begin
      bad_q <= 1'b1;
    end
  end
endmodule : arm_relay_lamp

// ### bench/arm_relay_ctrl_test.sv
// Self-checking bench for the alarm relay controller with a lamp on its contacts.
// Assumes the bound checker and a toggle period shortened to a few cycles.
`timescale 1ns/10ps
module arm_relay_ctrl_test;
  import arm_pkg::*;
  localparam int TGL = 8;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic              hsel = 1'b0;
  logic [7:0]        haddr = 8'h00;
  logic [1:0]        htrans = 2'h0;
  logic              hwrite = 1'b0;
  logic [31:0]       hwdata = 32'h0;
  logic              expansion_fitted = 1'b1;
  logic              grid_connected = 1'b0;
  logic              normal_operation = 1'b0;
  logic [N_CODE-1:0] code_active = '0;
  logic [VIN_W-1:0]  input_voltage = '0;
  logic              chain_in = 1'b0;
  logic [31:0]       hrdata;
  logic              hreadyout;
  logic              relay_no_closed;
  logic              relay_nc_closed;
  logic              irq;
  logic              lamp_on;
  logic [15:0]       flash_cnt;
  logic              bad_q;
  logic [31:0]       r;
  logic [N_CODE-1:0] c;
  logic              ds;
  integer            seed = 32'hf6616b41;
  int                fails = 0;
  int                compares = 0;
  int                v;

  always #2 clk = ~clk;

  arm_relay_ctrl #(.TOGGLE_CYCLES(TGL)) uut (.clk, .rstn, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(),
    .expansion_fitted, .grid_connected, .normal_operation, .code_active, .input_voltage,
    .chain_in, .relay_no_closed, .relay_nc_closed, .irq);
  arm_relay_lamp lamp (.clk, .rstn, .relay_no_closed, .relay_nc_closed, .lamp_on,
    .flash_cnt, .bad_q);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  // Waits out the mode decode and the forced rest cycle that follow a mode change.
  task automatic mode_set(input logic [3:0] m);
    bus(1'b1, ADDR_CTRL, {28'h0, m});
    repeat (3) @(posedge clk);
  endtask : mode_set

  task automatic relay_is(input logic e);
    repeat (3) @(posedge clk);
    check({30'h0, relay_nc_closed, relay_no_closed}, {30'h0, !e, e});
  endtask : relay_is

  function automatic logic nolatch_exp(input logic [N_CODE-1:0] k);
    return |k[N_ERR-1:0] || |k[WARN_GRID_HI:WARN_GRID_LO];
  endfunction : nolatch_exp

  function automatic logic dusk_exp(input int vin, input int act, input logic s);
    return (vin > act) ? 1'b1 : ((vin * 10 < act * 7) ? 1'b0 : s);
  endfunction : dusk_exp

  task automatic wrap_up;
    $display("counts: compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #200000;
    fails++;
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check({31'h0, relay_no_closed}, 32'h0);
    check({31'h0, irq}, 32'h0);
    bus(1'b0, ADDR_CTRL, 32'h0);
    check(r, 32'h0);
    bus(1'b0, 8'h18, 32'h0);
    check(r, 32'h0);
    for (int m = 0; m < 9; m++) begin
      mode_set(4'(m));
      bus(1'b0, ADDR_STATUS, 32'h0);
      check({23'h0, r[18:10]}, 32'h1 << m);
    end
    $display("test modes done");
    mode_set(MC_PRODUCTION);
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      grid_connected <= v[0];
      relay_is(v[0]);
    end
    grid_connected <= 1'b1;
    expansion_fitted <= 1'b0;
    relay_is(1'b0);
    expansion_fitted <= 1'b1;
    relay_is(1'b1);
    $display("test production done");
    grid_connected <= 1'b0;
    mode_set(MC_ALL_NOLATCH);
    for (int i = 0; i < 12; i++) begin
      c = '0;
      v = $random(seed);
      case (i % 4)
        0: c[{v[15:0]} % N_ERR] = 1'b1;
        1: c[WARN_GRID_LO + {v[15:0]} % 5] = 1'b1;
        2: c[WARN_UV] = 1'b1;
        default: c = '0;
      endcase
      code_active <= c;
      relay_is(nolatch_exp(c));
    end
    $display("test all no-latch done");
    bus(1'b1, ADDR_SEL_BASE + 8'h0c, 32'h4);
    mode_set(MC_CONF_NOLAT);
    v = flash_cnt;
    c = '0;
    c[WARN_UV] = 1'b1;
    code_active <= c;
    repeat (6 * TGL) @(posedge clk);
    check({31'h0, 32'(flash_cnt) - v >= 2}, 32'h1);
    code_active <= '0;
    relay_is(1'b0);
    code_active[5] <= 1'b1;
    relay_is(1'b0);
    $display("test configurable done");
    code_active <= '0;
    bus(1'b1, ADDR_VACT, 32'd1000);
    mode_set(MC_DUSK_DAWN);
    ds = 1'b0;
    for (int i = 0; i < 12; i++) begin
      case (i)
        0: v = 1001;
        1: v = 700;
        2: v = 699;
        3: v = 1000;
        default: v = 600 + {$random(seed)} % 500;
      endcase
      input_voltage <= 16'(v);
      ds = dusk_exp(v, 1000, ds);
      relay_is(ds);
    end
    $display("test dusk done");
    bus(1'b1, ADDR_IRQ_CLR, 32'h7);
    bus(1'b1, ADDR_IRQ_EN, 32'h1);
    mode_set(MC_ALL_LATCH);
    code_active[10] <= 1'b1;
    relay_is(1'b1);
    check({31'h0, irq}, 32'h1);
    code_active <= '0;
    repeat (10) @(posedge clk);
    relay_is(1'b1);
    bus(1'b0, ADDR_IRQ_STAT, 32'h0);
    check({31'h0, r[0]}, 32'h1);
    bus(1'b1, ADDR_IRQ_EN, 32'h0);
    relay_is(1'b1);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, ADDR_IRQ_CLR, 32'h7);
    bus(1'b0, ADDR_IRQ_STAT, 32'h0);
    check(r, 32'h0);
    bus(1'b1, ADDR_IRQ_EN, 32'h2);
    normal_operation <= 1'b1;
    grid_connected <= 1'b1;
    relay_is(1'b0);
    check({31'h0, irq}, 32'h1);
    $display("test latch and interrupt done");
    normal_operation <= 1'b0;
    bus(1'b1, ADDR_SEL_BASE, 32'h60);
    bus(1'b1, ADDR_LAT_BASE, 32'h20);
    mode_set(MC_EXT_MATRIX);
    for (int i = 0; i < 4; i++) begin
      c = '0;
      c[6 - i / 2] = !i[0];
      code_active <= c;
      relay_is(i != 1);
    end
    normal_operation <= 1'b1;
    relay_is(1'b0);
    c[6] = 1'b1;
    mode_set(MC_CHAIN_AUTO);
    code_active <= c;
    relay_is(1'b1);
    normal_operation <= 1'b0;
    mode_set(MC_CONF_LATCH);
    code_active <= '0;
    relay_is(1'b1);
    mode_set(MC_CHAIN_FOLL);
    chain_in <= 1'b1;
    relay_is(1'b1);
    chain_in <= 1'b0;
    relay_is(1'b0);
    $display("test matrix and chain done");
    check({31'h0, bad_q}, 32'h0);
    wrap_up();
  end
endmodule : arm_relay_ctrl_test
